// ===== i2crs_defs.svh
`ifndef I2CRS_DEFS_SVH
`define I2CRS_DEFS_SVH

// ----------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------
// 7-bit slave address, giving 0x86 for writes and 0x87 for reads
`define I2CRS_SLV_ADDR 7'h43
// Upper five bits of the high-speed master code
`define I2CRS_MCODE 5'h01
// General call address, never answered
`define I2CRS_GCALL 7'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define I2CRS_CLK_NS 5
// Shortest bus clock periods: 1 MHz and 3.4 MHz
`define I2CRS_LS_PER_NS 1000
`define I2CRS_HS_PER_NS 294
// Quarter bit times in cycles, rounded up so the rate is never exceeded
`define I2CRS_LS_QTR ((`I2CRS_LS_PER_NS + 4 * `I2CRS_CLK_NS - 1) / (4 * `I2CRS_CLK_NS))
`define I2CRS_HS_QTR ((`I2CRS_HS_PER_NS + 4 * `I2CRS_CLK_NS - 1) / (4 * `I2CRS_CLK_NS))
// Longest spike each filter set suppresses
`define I2CRS_LS_SPIKE_NS 50
`define I2CRS_HS_SPIKE_NS 10
`define I2CRS_LS_FILT (`I2CRS_LS_SPIKE_NS / `I2CRS_CLK_NS)
`define I2CRS_HS_FILT (`I2CRS_HS_SPIKE_NS / `I2CRS_CLK_NS)

// ----------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------
`define I2CRS_FIFO_W 16
`define I2CRS_FIFO_D 16

`endif

// ===== i2crs_pkg.sv
package i2crs_pkg;

  // Slave protocol states, Gray along the write path and the read data loop
  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_ADDR      = 4'h1,
    S_ADDR_ACK  = 4'h3,
    S_PTR       = 4'h2,
    S_PTR_ACK   = 4'h6,
    S_WDATA     = 4'h7,
    S_WDATA_ACK = 4'h5,
    S_RDATA     = 4'h4,
    S_RDATA_ACK = 4'hC,
    S_IGNORE    = 4'hD
  } i2crs_sstate_type;

  // Master sequencer states
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_HOLD = 2'h1,
    M_RUN  = 2'h3
  } i2crs_mstate_type;

  // Master user commands
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ  = 2'h3
  } i2crs_cmd_type;

endpackage

// ===== i2crs_if.sv
`timescale 1ns/100ps
interface i2crs_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;

  // Open-drain wires: idle high, any enabled low driver wins
  assign scl = (m_scl_oe & ~m_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o)) ? 1'b0 : 1'b1;

  modport master (input scl, input sda,
                  output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
  // The slave has no clock driver at all
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ===== i2crs_fifo.sv
`timescale 1ns/100ps
module i2crs_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                full;
    logic                empty;
  } i2crs_fifo_st_type;

  i2crs_fifo_st_type r_reg;
  i2crs_fifo_st_type r_next;
  logic              push;
  logic              pop;

  // Pointers and flags; full and empty are flops for clean outputs
  always_comb begin
    r_next = r_reg;
    push = i_valid & ~r_reg.full;
    pop  = i_ready & ~r_reg.empty;
    if (push) begin
      r_next.mem[r_reg.wp] = i_data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    r_next.cnt   = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    r_next.full  = (r_next.cnt == (AW+1)'(D));
    r_next.empty = (r_next.cnt == '0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg       <= '0;
      r_reg.empty <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Head word is read straight from the storage array
  assign o_ready = ~r_reg.full;
  assign o_valid = ~r_reg.empty;
  assign o_data  = r_reg.mem[r_reg.rp];
endmodule

// ===== i2crs_slave.sv
`timescale 1ns/100ps
`include "i2crs_defs.svh"

// Function
// - Accept any bus rate up to 1MHz
// - Never hold the clock line low
// - Slow filters at reset and after STOP
// - High-speed mode uses the faster filter set
// - Master enters high speed only from slow bus
// - Master code 00001xxx is never acknowledged
// - After master code, master speeds up, repeats START
// - High speed lasts until STOP, then re-entry needed
// - Write starts with address, slave acknowledges it
// - Pointer byte follows, slave acknowledges it
// - Acked data byte loads at following falling edge
// - Pointer advances after each written byte
// - Master ends write with STOP or repeated START
// - Read: pointer write, repeated START, address, data
// - Master ack advances pointer, next byte follows
// - Master ends read with nack then STOP/START
// - Mismatched address: stay idle until next START
// - General call address is not acknowledged
// - Address byte is 0x86 write, 0x87 read
module i2crs_slave
  import i2crs_pkg::*;
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // Two-wire bus
  i2crs_if.slave     bus,
  // Register read side
  output logic [7:0] o_rd_addr,
  input  wire logic [7:0] i_rd_data,
  // Register write stream
  output logic       o_wr_valid,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  input  wire logic  i_wr_ready,
  // Status
  output logic       o_hs
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    i2crs_sstate_type st;
    logic [1:0]       fl;
    logic [1:0][3:0]  fc;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic [7:0]       tx;
    logic [7:0]       wd;
    logic [7:0]       wa;
    logic [7:0]       ptr;
    logic             rw;
    logic             hs;
    logic             sda_oe;
    logic             push;
  } i2crs_slave_st_type;

  i2crs_slave_st_type r_reg;
  i2crs_slave_st_type r_next;
  logic [1:0]         raw;
  logic [3:0]         lim;
  logic               scl_rise;
  logic               scl_fall;
  logic               start;
  logic               stop;
  logic               fifo_ready;
  logic [15:0]        fifo_out;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.push = 1'b0;
    raw = {bus.scl, bus.sda};
    // Filter length follows the speed class
    lim = r_reg.hs ? 4'(`I2CRS_HS_FILT) : 4'(`I2CRS_LS_FILT);
    // Glitch filter: a level must hold lim cycles before it is believed
    for (int i = 0; i < 2; i++) begin
      if (raw[i] == r_reg.fl[i]) begin
        r_next.fc[i] = 4'h0;
      end else if (r_reg.fc[i] >= lim - 4'h1) begin
        r_next.fl[i] = raw[i];
        r_next.fc[i] = 4'h0;
      end else begin
        r_next.fc[i] = r_reg.fc[i] + 4'h1;
      end
    end

    // Edge and condition detect; no timeouts, so any slow rate works
    scl_rise = ~r_reg.fl[1] & r_next.fl[1];
    scl_fall = r_reg.fl[1] & ~r_next.fl[1];
    start    = r_reg.fl[1] & r_next.fl[1] & r_reg.fl[0] & ~r_next.fl[0];
    stop     = r_reg.fl[1] & r_next.fl[1] & ~r_reg.fl[0] & r_next.fl[0];

    if (start) begin
      // Any START, repeated or not, restarts address matching
      r_next.st     = S_ADDR;
      r_next.cnt    = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop) begin
      // STOP drops back to slow filters and ends high speed
      r_next.st     = S_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.hs     = 1'b0;
    end else if (scl_rise) begin
      // Sample on the rising edge, data is stable while clock is high
      r_next.sh  = {r_reg.sh[6:0], r_next.fl[0]};
      r_next.cnt = r_reg.cnt + 4'h1;
      if (r_reg.st == S_RDATA_ACK && !r_next.fl[0]) begin
        // Advance early so read data has many cycles to settle
        r_next.ptr = r_reg.ptr + 8'h01;
      end
    end else if (scl_fall) begin
      // All data line changes happen just after the clock falls
      case (r_reg.st)
        S_ADDR: begin
          if (r_reg.cnt == 4'h8) begin
            if (r_reg.sh[7:1] == `I2CRS_SLV_ADDR) begin
              r_next.sda_oe = 1'b1;
              r_next.rw     = r_reg.sh[0];
              r_next.st     = S_ADDR_ACK;
            end else begin
              // Foreign address, general call or master code: no ack
              r_next.st = S_IGNORE;
              if (r_reg.sh[7:3] == `I2CRS_MCODE) begin
                r_next.hs = 1'b1;
              end
            end
          end
        end
        S_ADDR_ACK: begin
          r_next.cnt = 4'h0;
          if (r_reg.rw) begin
            // Read: first bit goes out on the same falling edge
            r_next.tx     = i_rd_data;
            r_next.sda_oe = ~i_rd_data[7];
            r_next.st     = S_RDATA;
          end else begin
            r_next.sda_oe = 1'b0;
            r_next.st     = S_PTR;
          end
        end
        S_PTR: begin
          if (r_reg.cnt == 4'h8) begin
            r_next.ptr    = r_reg.sh;
            r_next.sda_oe = 1'b1;
            r_next.st     = S_PTR_ACK;
          end
        end
        S_PTR_ACK: begin
          r_next.sda_oe = 1'b0;
          r_next.cnt    = 4'h0;
          r_next.st     = S_WDATA;
        end
        S_WDATA: begin
          if (r_reg.cnt == 4'h8) begin
            // A full buffer cannot be stalled by the clock, so refuse
            if (fifo_ready) begin
              r_next.wd     = r_reg.sh;
              r_next.sda_oe = 1'b1;
              r_next.st     = S_WDATA_ACK;
            end else begin
              r_next.st = S_IGNORE;
            end
          end
        end
        S_WDATA_ACK: begin
          // Falling edge after the ack commits the byte
          r_next.push   = 1'b1;
          r_next.wa     = r_reg.ptr;
          r_next.ptr    = r_reg.ptr + 8'h01;
          r_next.sda_oe = 1'b0;
          r_next.cnt    = 4'h0;
          r_next.st     = S_WDATA;
        end
        S_RDATA: begin
          if (r_reg.cnt == 4'h8) begin
            r_next.sda_oe = 1'b0;
            r_next.st     = S_RDATA_ACK;
          end else begin
            r_next.tx     = {r_reg.tx[6:0], 1'b0};
            r_next.sda_oe = ~r_reg.tx[6];
          end
        end
        S_RDATA_ACK: begin
          r_next.cnt = 4'h0;
          if (!r_reg.sh[0]) begin
            r_next.tx     = i_rd_data;
            r_next.sda_oe = ~i_rd_data[7];
            r_next.st     = S_RDATA;
          end else begin
            // Master is done; stay off the bus until a START
            r_next.st = S_IGNORE;
          end
        end
        default: begin
          r_next.st = r_reg.st;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Idle bus reads high, so filtered levels reset high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg    <= '0;
      r_reg.fl <= 2'b11;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  i2crs_fifo #(
    .W (`I2CRS_FIFO_W),
    .D (`I2CRS_FIFO_D)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (r_reg.push),
    .i_data  ({r_reg.wa, r_reg.wd}),
    .o_ready (fifo_ready),
    .o_valid (o_wr_valid),
    .o_data  (fifo_out),
    .i_ready (i_wr_ready)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only the data line is driven; the clock is never held
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = r_reg.sda_oe;
  assign o_rd_addr    = r_reg.ptr;
  assign o_wr_addr    = fifo_out[15:8];
  assign o_wr_data    = fifo_out[7:0];
  assign o_hs         = r_reg.hs;
endmodule

// ===== i2crs_master.sv
`timescale 1ns/100ps
`include "i2crs_defs.svh"
module i2crs_master
  import i2crs_pkg::*;
(
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // Two-wire bus
  i2crs_if.master    bus,
  // Command
  input  wire logic  i_cmd_valid,
  input  i2crs_cmd_type i_cmd,
  input  wire logic [7:0] i_cmd_data,
  output logic       o_cmd_ready,
  // Response
  output logic       o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic       o_rsp_ack,
  output logic       o_hs
);

  typedef struct packed {
    i2crs_mstate_type st;
    i2crs_cmd_type    op;
    logic [1:0]       ph;
    logic [7:0]       tmr;
    logic [3:0]       bitn;
    logic [7:0]       sh;
    logic             nack;
    logic             ack;
    logic             first;
    logic             hs;
    logic             scl_oe;
    logic             sda_oe;
    logic             ready;
    logic             rsp_valid;
  } i2crs_master_st_type;

  i2crs_master_st_type r_reg;
  i2crs_master_st_type r_next;
  logic [7:0]          qlen;
  logic                enter;
  logic                done;

  // ----------------------------------------------------------------
  // Sequencer: four quarter phases per bit or condition
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    enter = 1'b0;
    done  = 1'b0;
    // Slow timing until the master code has gone unanswered
    qlen = r_reg.hs ? 8'(`I2CRS_HS_QTR - 1) : 8'(`I2CRS_LS_QTR - 1);
    if (r_reg.st != M_RUN) begin
      if (r_reg.ready && i_cmd_valid) begin
        r_next.ready = 1'b0;
        r_next.op    = i_cmd;
        r_next.sh    = i_cmd_data;
        r_next.nack  = i_cmd_data[0];
        r_next.st    = M_RUN;
        r_next.ph    = 2'h0;
        r_next.tmr   = 8'h00;
        r_next.bitn  = 4'h0;
        enter = 1'b1;
      end
    end else if (r_reg.tmr != qlen) begin
      r_next.tmr = r_reg.tmr + 8'h01;
    end else begin
      r_next.tmr = 8'h00;
      r_next.ph  = r_reg.ph + 2'h1;
      enter = 1'b1;
      if (r_reg.ph == 2'h3) begin
        if (r_reg.op == CMD_START || r_reg.op == CMD_STOP || r_reg.bitn == 4'h8) begin
          done  = 1'b1;
          enter = 1'b0;
        end else begin
          r_next.bitn = r_reg.bitn + 4'h1;
        end
      end
    end

    // Actions taken on entering each phase
    if (enter) begin
      case (r_next.ph)
        2'h0: begin
          case (r_next.op)
            CMD_START: r_next.sda_oe = 1'b0;
            CMD_STOP:  r_next.sda_oe = 1'b1;
            CMD_WRITE: r_next.sda_oe = (r_next.bitn == 4'h8) ? 1'b0 : ~r_next.sh[7];
            default:   r_next.sda_oe = (r_next.bitn == 4'h8) ? ~r_next.nack : 1'b0;
          endcase
        end
        2'h1: begin
          r_next.scl_oe = 1'b0;
        end
        2'h2: begin
          // Mid-high sample; bit data changes only while the clock is low, START and STOP move it here
          if (r_next.op == CMD_START) begin
            r_next.sda_oe = 1'b1;
          end else if (r_next.op == CMD_STOP) begin
            r_next.sda_oe = 1'b0;
          end else if (r_next.bitn == 4'h8) begin
            r_next.ack = ~bus.sda;
          end else begin
            r_next.sh = {r_reg.sh[6:0], bus.sda};
          end
        end
        default: begin
          r_next.scl_oe = (r_next.op != CMD_STOP);
        end
      endcase
    end

    // Completion and the high-speed entry and exit bookkeeping
    if (done) begin
      r_next.ready     = 1'b1;
      r_next.rsp_valid = 1'b1;
      r_next.st        = M_HOLD;
      r_next.first     = 1'b0;
      case (r_reg.op)
        CMD_START: r_next.first = 1'b1;
        CMD_STOP: begin
          r_next.st = M_IDLE;
          r_next.hs = 1'b0;
        end
        CMD_WRITE: begin
          if (r_reg.first && !r_reg.ack && r_reg.sh[7:3] == `I2CRS_MCODE) begin
            r_next.hs = 1'b1;
          end
        end
        default: r_next.first = 1'b0;
      endcase
    end
  end

  // Reset releases both lines and leaves the command port open
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg       <= '0;
      r_reg.ready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Open-drain drivers: only ever pull low, never drive high
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = r_reg.scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = r_reg.sda_oe;
  assign o_cmd_ready  = r_reg.ready;
  assign o_rsp_valid  = r_reg.rsp_valid;
  assign o_rsp_data   = r_reg.sh;
  assign o_rsp_ack    = r_reg.ack;
  assign o_hs         = r_reg.hs;
endmodule

// ===== i2crs_props.sv
`timescale 1ns/100ps
module i2crs_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Line drivers
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // Byte tracker
  // ----------------------------------------------------------------
  logic       scl_reg, sda_reg, first_reg, rd_reg, quiet_reg;
  logic [3:0] bit_reg;
  logic [7:0] byte_reg, low_reg;
  logic       start_det, rise, ack_rise;

  assign start_det = scl && scl_reg && sda_reg && !sda;
  assign rise      = scl && !scl_reg;
  assign ack_rise  = rise && (bit_reg == 4'h8);

  // Raw lines are clean here; no filter needed on the observer side
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_reg   <= 1'b1;
      sda_reg   <= 1'b1;
      first_reg <= 1'b0;
      rd_reg    <= 1'b0;
      quiet_reg <= 1'b0;
      bit_reg   <= 4'h0;
      byte_reg  <= 8'h00;
      low_reg   <= 8'h00;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      low_reg <= scl ? 8'h00 : ((low_reg == 8'hFF) ? low_reg : low_reg + 8'h01);
      if (start_det) begin
        bit_reg   <= 4'h0;
        first_reg <= 1'b1;
        quiet_reg <= 1'b0;
      end else if (ack_rise) begin
        bit_reg   <= 4'h0;
        first_reg <= 1'b0;
        if (first_reg) begin
          rd_reg <= byte_reg[0];
        end
        // Foreign address or master nack on read silences the slave
        if ((first_reg && byte_reg[7:1] != 7'h43) || (!first_reg && rd_reg && sda)) begin
          quiet_reg <= 1'b1;
        end
      end else if (rise) begin
        bit_reg  <= bit_reg + 4'h1;
        byte_reg <= {byte_reg[6:0], sda};
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_addr_slot;
    ack_rise && first_reg;
  endsequence

  clk_follow_a: assert property (!scl |-> m_scl_oe && !m_scl_o)
    else $error("clock low without master drive");
  reset_idle_a: assert property (
    $rose(i_rst_n) |-> !s_sda_oe && !m_scl_oe && !m_sda_oe)
    else $error("bus not released after reset");
  hold_high_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave data changed while clock high");
  drive_window_a: assert property (
    $rose(s_sda_oe) |-> !scl && low_reg inside {[2:20]})
    else $error("slave drive outside clock low window");
  release_low_a: assert property ($fell(s_sda_oe) |-> !scl)
    else $error("slave released while clock high");
  mcode_nack_a: assert property (s_addr_slot and byte_reg[7:3] == 5'h01 |-> sda)
    else $error("master code acknowledged");
  gcall_nack_a: assert property (s_addr_slot and byte_reg[7:1] == 7'h00 |-> sda)
    else $error("general call acknowledged");
  addr_ack_a: assert property (
    s_addr_slot and byte_reg[7:1] == 7'h43 |-> s_sda_oe && !s_sda_o)
    else $error("own address not acknowledged");
  quiet_slave_a: assert property (quiet_reg |-> !s_sda_oe)
    else $error("slave drove data while ignoring");
  start_free_a: assert property (s_start |-> m_sda_oe && !m_sda_o && !s_sda_oe)
    else $error("start not made by master alone");
endmodule

// ===== i2c_register_slave_hs_tb.sv
`timescale 1ns/100ps
module i2c_register_slave_hs_tb
  import i2crs_pkg::*;
;
  logic          clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_ack, m_hs;
  i2crs_cmd_type cmd;
  logic [7:0]    cmd_data, rsp_data, rd_addr, rd_data, wr_addr, wr_data;
  logic          wr_valid, wr_ready, s_hs;
  int            num_errors, checked, cycles;

  // ----------------------------------------------------------------
  // Both ends and the observer
  // ----------------------------------------------------------------
  i2crs_if i_i2crs_if ();
  i2crs_master i_i2crs_master (.i_clk(clk), .i_rst_n(rst_n), .bus(i_i2crs_if),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_rsp_ack(rsp_ack), .o_hs(m_hs));
  i2crs_slave i_i2crs_slave (.i_clk(clk), .i_rst_n(rst_n), .bus(i_i2crs_if),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .i_wr_ready(wr_ready), .o_hs(s_hs));
  i2crs_props i_i2crs_props (.i_clk(clk), .i_rst_n(rst_n), .scl(i_i2crs_if.scl),
    .sda(i_i2crs_if.sda), .m_scl_o(i_i2crs_if.m_scl_o), .m_scl_oe(i_i2crs_if.m_scl_oe),
    .m_sda_o(i_i2crs_if.m_sda_o), .m_sda_oe(i_i2crs_if.m_sda_oe),
    .s_sda_o(i_i2crs_if.s_sda_o), .s_sda_oe(i_i2crs_if.s_sda_oe));

  // Register contents differ from their address so a stale pointer shows
  assign rd_data = rd_addr ^ 8'hA5;

  always #2.5 clk = ~clk;

  // Hang guard, well above the roughly 60k cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  // One command, held for a single cycle, then wait for its completion pulse
  task automatic do_cmd(input i2crs_cmd_type c, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do @(negedge clk); while (rsp_valid !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] b, input logic ack);
    do_cmd(CMD_WRITE, b);
    chk_bit(rsp_ack, ack);
  endtask

  task automatic rd(input logic nack, input logic [7:0] exp);
    do_cmd(CMD_READ, {7'h00, nack});
    chk_byte(rsp_data, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Fill the buffer past full with the far side stalled, then drain
  task automatic t_fill();
    int i;
    do_cmd(CMD_START, 8'h00);
    wr(8'h86, 1'b1);
    wr(8'hF8, 1'b1);
    for (i = 0; i < 16; i++) begin
      wr(8'h30 + 8'(i), 1'b1);
    end
    wr(8'hEE, 1'b0);
    do_cmd(CMD_STOP, 8'h00);
    for (i = 0; i < 16; i++) begin
      repeat (2) @(negedge clk);
      chk_bit(wr_valid, 1'b1);
      chk_byte(wr_addr, 8'hF8 + 8'(i));
      chk_byte(wr_data, 8'h30 + 8'(i));
      @(posedge clk);
      wr_ready <= 1'b1;
      @(posedge clk);
      wr_ready <= 1'b0;
    end
    repeat (2) @(negedge clk);
    chk_bit(wr_valid, 1'b0);
  endtask

  // Sequential read across the pointer wrap, ended by a nack
  task automatic t_read();
    do_cmd(CMD_START, 8'h00);
    wr(8'h86, 1'b1);
    wr(8'hFF, 1'b1);
    do_cmd(CMD_START, 8'h00);
    wr(8'h87, 1'b1);
    rd(1'b0, 8'h5A);
    rd(1'b0, 8'hA5);
    rd(1'b1, 8'hA4);
    do_cmd(CMD_STOP, 8'h00);
    chk_byte(rd_addr, 8'h01);
  endtask

  // General call and foreign address ignored until the next start
  task automatic t_refuse();
    do_cmd(CMD_START, 8'h00);
    wr(8'h00, 1'b0);
    do_cmd(CMD_START, 8'h00);
    wr(8'h92, 1'b0);
    wr(8'h55, 1'b0);
    do_cmd(CMD_START, 8'h00);
    wr(8'h86, 1'b1);
    do_cmd(CMD_STOP, 8'h00);
    chk_bit(wr_valid, 1'b0);
  endtask

  // Entry always begins on the slow bus, then the master code goes out
  task automatic hs_enter(input logic [7:0] code);
    chk_bit(m_hs, 1'b0);
    do_cmd(CMD_START, 8'h00);
    wr(code, 1'b0);
    chk_bit(s_hs, 1'b1);
    chk_bit(m_hs, 1'b1);
    do_cmd(CMD_START, 8'h00);
    wr(8'h86, 1'b1);
  endtask

  // Fast writes, exit at stop, re-entry, then reset in mid-transfer
  task automatic t_hs();
    chk_bit(s_hs, 1'b0);
    hs_enter(8'h0B);
    wr(8'h40, 1'b1);
    wr(8'h99, 1'b1);
    do_cmd(CMD_STOP, 8'h00);
    repeat (20) @(negedge clk);
    chk_bit(s_hs, 1'b0);
    chk_bit(wr_valid, 1'b1);
    chk_byte(wr_addr, 8'h40);
    chk_byte(wr_data, 8'h99);
    hs_enter(8'h0F);
    wr(8'h5A, 1'b1);
    chk_byte(rd_addr, 8'h5A);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_bit(s_hs, 1'b0);
    chk_byte(rd_addr, 8'h00);
    chk_bit(wr_valid, 1'b0);
    chk_bit(cmd_ready, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = CMD_START;
    cmd_data = 8'h00;
    wr_ready = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    t_fill();
    t_read();
    t_refuse();
    t_hs();
    summarize();
  end
endmodule
